//--- rtl/rsf_top.sv
// Reset source flag block: APB registers, reset sources and standby release.
//
// Notes on behaviour
// RULE1 - A non-maskable interrupt that ends sub-IDLE or low-voltage sub-IDLE always branches.
// RULE2 - A maskable wake branches or continues with interrupts enabled, and continues if disabled.
// RULE3 - A reset that ends either standby mode is an ordinary reset in every respect.
// RULE4 - Four reset sources exist, the low external pin being one of them.
// RULE5 - A second watchdog overflow requests a reset of the whole system.
// RULE6 - The low-voltage detector resets the system when its comparison calls for it.
// RULE7 - The oscillation stop monitor resets the system when the main oscillator stops.
// RULE8 - A watchdog overflow in the stabilisation wait starts the CPU on the internal clock.
// RULE9 - In emergency mode software touches only interrupt, port, watchdog and timer M registers.
// RULE10 - In emergency mode software does not run the serial ports from an external clock.
// RULE11 - The reset cause register takes a write only through the protected sequence.
// RULE12 - The reset cause register is reached by byte and by single-bit accesses.
// RULE13 - The external pin reset clears the reset cause register to zero.
// RULE14 - Watchdog flag sits in bit 4, clock stop in bit 1, low voltage in bit 0, others read 0.
// RULE15 - After a reset from another source the register is non-zero and names that source.
// RULE16 - An internal reset sets only its own flag and keeps the other flags.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module rsf_top
  import rsf_pkg::*;
#(
  parameter int STAB_CYC = STAB_CYCLES,
  parameter int HOLD_CYC = HOLD_CYCLES
) (
  // Clock and external reset pin, the master clear.
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Reset requests from the watchdog, voltage detector and clock monitor.
  input  wire logic              watchdog_reset_request,
  input  wire logic              low_voltage_reset_request,
  input  wire logic              oscillation_stop_request,
  // Wake sources and CPU state during standby.
  input  wire logic              nmi_request,
  input  wire logic              maskable_request,
  input  wire logic              interrupts_enabled_state,
  input  wire logic              request_outranks_current,
  // System and clock control outputs.
  output logic                   system_reset,
  output logic                   stabilization_wait,
  output logic                   cpu_on_internal_clock,
  // Standby outputs.
  output logic                   standby_active,
  output logic                   low_voltage_standby,
  output logic                   wake_branch,
  output logic                   wake_continue
);

  if (STAB_CYC < 1 || HOLD_CYC < 1) begin : g_chk
    $error("rsf_top: stabilisation and hold counts must be at least one cycle.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [7:0]    flags;
    logic          armed;
    logic [2:0]    bit_idx;
    rsf_sb_state_t sb;
    logic          wake_branch;
    logic          wake_continue;
    logic          pready;
    logic [31:0]   prdata;
    logic          pslverr;
  } rsf_top_reg_t;

  rsf_top_reg_t r;
  rsf_top_reg_t next_r;
  rsf_seq_if    sq_if ();

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  // Register map; every register is one 32-bit word with its data in bits 7:0, apart from the bit 8 value at 0x10.
  //   0x00  Reset cause flags; a write lands only as the transfer right after the key.
  //   0x04  Key; writing the key arms the next completed transfer, bit 0 reads armed.
  //   0x08  Status, read only: standby, low-voltage standby, system reset, stabilisation
  //         wait, emergency clock and armed, from bit 0 upwards.
  //   0x0C  Standby control; bit 0 enters standby, bit 1 picks the low-voltage variant.
  //         Entry is refused while the internal reset holds the system.
  //   0x10  Single-bit access; bits 2:0 pick a flag and bit 8 is the value to write.
  //         The index is always kept, the flag changes only when the key armed it,
  //         and a read returns the kept index above that flag's value.
  // Writes need byte lane 0, single-bit writes lane 1 as well; other writes are dropped.
  // Any completed transfer other than the key disarms, so a stray read between the key
  // and the flag write loses the key, which is the protection the flags rely on.
  // Unmapped offsets answer with an error and read zero; the only state they touch is the key, which they disarm.
  // Reserved flag bits are masked on every path, so they always read zero.

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFF_FLAGS) || (a == OFF_PROTECT) || (a == OFF_STATUS) ||
           (a == OFF_CTRL) || (a == OFF_BITOP);
  endfunction

  function automatic logic is_flag_write(input logic [ADDR_W-1:0] a);
    return (a == OFF_FLAGS) || (a == OFF_BITOP);
  endfunction

  // Status byte as software reads it.
  function automatic logic [7:0] status_byte(input rsf_sb_state_t sb,
                                             input logic          sys_rst,
                                             input logic          stab,
                                             input logic          emerg,
                                             input logic          armed);
    logic [7:0] s;
    s              = 8'h00;
    s[STAT_SB]     = sb[0];
    s[STAT_LV]     = sb[1];
    s[STAT_SYSRST] = sys_rst;
    s[STAT_STAB]   = stab;
    s[STAT_EMERG]  = emerg;
    s[STAT_ARMED]  = armed;
    return s;
  endfunction

  // Read word for an offset; unmapped offsets read zero.
  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                            input rsf_top_reg_t      s,
                                            input logic [7:0]        stat);
    logic [31:0] w;
    w = RDATA_ZERO;
    unique case (a)
      OFF_FLAGS:   w = {24'h00_0000, s.flags & FLAGS_MASK}; // [RULE12] [RULE14]
      OFF_PROTECT: w = {31'h0000_0000, s.armed};
      OFF_STATUS:  w = {24'h00_0000, stat};
      OFF_CTRL:    w = {30'h0000_0000, s.sb};
      // Single-bit read of the last selected flag.
      OFF_BITOP:   w = {28'h000_0000, s.bit_idx, s.flags[s.bit_idx]}; // [RULE12]
      default:     w = RDATA_ZERO;
    endcase
    return w;
  endfunction

  // How the CPU resumes when an interrupt ends standby, as {branch, continue}.
  function automatic logic [1:0] wake_kind(input logic nmi,
                                           input logic maskable,
                                           input logic ei,
                                           input logic outranks);
    logic [1:0] k;
    k = 2'h0;
    if (nmi) begin
      k = 2'h2; // [RULE1]
    end else if (maskable && ei && outranks) begin
      k = 2'h2; // [RULE2]
    end else if (maskable) begin
      k = 2'h1; // [RULE2]
    end
    return k;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer.

  assign sq_if.wdt_req = watchdog_reset_request;
  assign sq_if.lvi_req = low_voltage_reset_request;
  assign sq_if.clm_req = oscillation_stop_request;

  rsf_seq #(
    .STAB_CYC (STAB_CYC),
    .HOLD_CYC (HOLD_CYC)
  ) u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .sq      (sq_if.seq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  logic       acc_done;
  logic       acc_start;
  logic [7:0] hw_set;
  logic [7:0] bit_sel;
  logic [7:0] stat_byte;

  always_comb begin
    acc_start = psel && penable && !r.pready;
    acc_done  = psel && penable && r.pready;
    hw_set    = 8'h00;
    hw_set[LVI_BIT] = sq_if.hit[0]; // [RULE14] [RULE15]
    hw_set[CLM_BIT] = sq_if.hit[1]; // [RULE14] [RULE15]
    hw_set[WDT_BIT] = sq_if.hit[2]; // [RULE14] [RULE15]
    bit_sel   = 8'h01 << pwdata[BITOP_IDX_LO +: 3];
    stat_byte = status_byte(r.sb, sq_if.sys_reset, sq_if.stab_wait, sq_if.emergency,
                            r.armed);

    next_r               = r;
    next_r.wake_branch   = 1'b0;
    next_r.wake_continue = 1'b0;
    next_r.pready        = acc_start;

    // Read data and error are captured with pready, one cycle into the access.
    if (acc_start) begin
      next_r.pslverr = !is_mapped(paddr);
      next_r.prdata  = RDATA_ZERO;
      if (!pwrite) begin
        next_r.prdata = read_word(paddr, r, stat_byte); // [RULE12] [RULE14]
      end
    end

    // Register writes take effect at the completing edge only.
    if (acc_done) begin
      // The key arms exactly the next transfer; any other transfer disarms.
      next_r.armed = 1'b0; // [RULE11]
      if (pwrite && pstrb[0]) begin
        unique case (paddr)
          OFF_PROTECT: begin
            next_r.armed = (pwdata[7:0] == PROTECT_KEY); // [RULE11]
          end
          OFF_FLAGS: begin
            if (r.armed) begin
              next_r.flags = pwdata[7:0] & FLAGS_MASK; // [RULE11] [RULE12]
            end
          end
          OFF_BITOP: begin
            if (pstrb[1]) begin
              next_r.bit_idx = pwdata[BITOP_IDX_LO +: 3];
              if (r.armed) begin
                if (pwdata[BITOP_VAL]) begin
                  next_r.flags = (r.flags | bit_sel) & FLAGS_MASK; // [RULE12]
                end else begin
                  next_r.flags = r.flags & ~bit_sel; // [RULE12]
                end
              end
            end
          end
          OFF_CTRL: begin
            if (pwdata[CTRL_ENTER] && r.sb == SB_RUN && !sq_if.sys_reset) begin
              next_r.sb = pwdata[CTRL_LV] ? SB_LV_IDLE : SB_IDLE;
            end
          end
          default: begin
          end
        endcase
      end
      if (!is_flag_write(paddr) && pwrite && paddr == OFF_PROTECT && pstrb[0]) begin
        next_r.armed = (pwdata[7:0] == PROTECT_KEY);
      end
    end

    // Hardware set wins over a software clear in the same cycle.
    next_r.flags = next_r.flags | hw_set; // [RULE16]

    // Standby release.
    if (sq_if.sys_reset) begin
      // A reset during standby is an ordinary reset.
      next_r.sb            = SB_RUN; // [RULE3]
      next_r.wake_branch   = 1'b0;
      next_r.wake_continue = 1'b0;
    end else if (r.sb != SB_RUN) begin
      if (nmi_request || maskable_request) begin
        next_r.sb = SB_RUN;
        {next_r.wake_branch, next_r.wake_continue} = wake_kind(nmi_request, maskable_request,
                                                               interrupts_enabled_state,
                                                               request_outranks_current);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; the pin reset clears every flag.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.flags         <= FLAGS_RESET; // [RULE13] [RULE4]
      r.armed         <= 1'b0;
      r.bit_idx       <= 3'h0;
      r.sb            <= SB_RUN;
      r.wake_branch   <= 1'b0;
      r.wake_continue <= 1'b0;
      r.pready        <= 1'b0;
      r.prdata        <= RDATA_ZERO;
      r.pslverr       <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign pready                = r.pready;
  assign prdata                = r.prdata;
  assign pslverr               = r.pslverr;
  assign system_reset          = sq_if.sys_reset;
  assign stabilization_wait    = sq_if.stab_wait;
  assign cpu_on_internal_clock = sq_if.emergency; // [RULE8]
  assign standby_active        = r.sb[0];
  assign low_voltage_standby   = r.sb[1];
  assign wake_branch           = r.wake_branch;
  assign wake_continue         = r.wake_continue;

endmodule
`default_nettype wire

//--- rtl/rsf_pkg.sv
// Shared constants and types for the reset source flag block.
package rsf_pkg;

  // APB word offsets, byte addresses.
  localparam int            ADDR_W       = 12;
  localparam logic [11:0]   OFF_FLAGS    = 12'h000;
  localparam logic [11:0]   OFF_PROTECT  = 12'h004;
  localparam logic [11:0]   OFF_STATUS   = 12'h008;
  localparam logic [11:0]   OFF_CTRL     = 12'h00C;
  localparam logic [11:0]   OFF_BITOP    = 12'h010;

  // Reset cause flag positions and values.
  localparam int            LVI_BIT      = 0;
  localparam int            CLM_BIT      = 1;
  localparam int            WDT_BIT      = 4;
  localparam logic [7:0]    FLAGS_RESET  = 8'h00;
  localparam logic [7:0]    FLAGS_MASK   = 8'h13;

  // Protected write key and field positions of the helper registers.
  localparam logic [7:0]    PROTECT_KEY  = 8'hA5;
  localparam int            BITOP_IDX_LO = 0;
  localparam int            BITOP_VAL    = 8;
  localparam int            CTRL_ENTER   = 0;
  localparam int            CTRL_LV      = 1;
  localparam int            STAT_SB      = 0;
  localparam int            STAT_LV      = 1;
  localparam int            STAT_SYSRST  = 2;
  localparam int            STAT_STAB    = 3;
  localparam int            STAT_EMERG   = 4;
  localparam int            STAT_ARMED   = 5;
  localparam logic [31:0]   RDATA_ZERO   = 32'h0000_0000;

  // Timing at a 5 ns clock; least times round up.
  localparam int            CLK_PERIOD_NS = 5;
  localparam int            STAB_TIME_NS  = 50000;
  localparam int            HOLD_TIME_NS  = 100;
  localparam int            STAB_CYCLES   = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int            HOLD_CYCLES   = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Reset sequencer states, Gray along hold, stabilisation, run.
  typedef enum logic [1:0] {
    SEQ_HOLD = 2'b00,
    SEQ_STAB = 2'b01,
    SEQ_RUN  = 2'b11
  } rsf_seq_state_t;

  // Standby states; bit 0 is standby, bit 1 is the low-voltage variant.
  typedef enum logic [1:0] {
    SB_RUN     = 2'b00,
    SB_IDLE    = 2'b01,
    SB_LV_IDLE = 2'b11
  } rsf_sb_state_t;

endpackage

//--- rtl/rsf_seq_if.sv
// Interface between the register front end and the reset sequencer.
`timescale 1ns/1ps
`default_nettype none
interface rsf_seq_if;
  logic       wdt_req;
  logic       lvi_req;
  logic       clm_req;
  logic       sys_reset;
  logic       stab_wait;
  logic       emergency;
  logic [2:0] hit;

  modport front (output wdt_req, lvi_req, clm_req, input sys_reset, stab_wait, emergency, hit);
  modport seq   (input wdt_req, lvi_req, clm_req, output sys_reset, stab_wait, emergency, hit);
endinterface
`default_nettype wire

//--- rtl/rsf_seq.sv
// Reset sequencer: reset hold, stabilisation wait and emergency mode.
`timescale 1ns/1ps
`default_nettype none
module rsf_seq
  import rsf_pkg::*;
#(
  parameter int STAB_CYC = STAB_CYCLES,
  parameter int HOLD_CYC = HOLD_CYCLES
) (
  // Clock and pin reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Link to the front end.
  rsf_seq_if.seq    sq
);

  localparam int CW = $clog2(STAB_CYC + HOLD_CYC + 1);

  if (STAB_CYC < 1 || HOLD_CYC < 1) begin : g_chk
    $error("rsf_seq: stabilisation and hold counts must be at least one cycle.");
  end

  typedef struct packed {
    rsf_seq_state_t  state;
    logic [CW-1:0]   cnt;
    logic            sys_reset;
    logic            emergency;
    logic            stab_wait;
    logic [2:0]      hit;
  } rsf_seq_reg_t;

  rsf_seq_reg_t r;
  rsf_seq_reg_t next_r;

  always_comb begin
    next_r     = r;
    // Hit bits report accepted sources: 0 low voltage, 1 clock stop, 2 watchdog.
    next_r.hit = {sq.wdt_req && (r.state != SEQ_STAB), sq.clm_req, sq.lvi_req}; // [RULE16]
    unique case (r.state)
      SEQ_HOLD: begin
        if (r.cnt == '0) begin
          next_r.state     = SEQ_STAB;
          next_r.cnt       = CW'(STAB_CYC - 1);
          next_r.sys_reset = 1'b0;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      SEQ_STAB: begin
        if (sq.wdt_req) begin
          // Main oscillator judged faulty: run on the internal clock.
          next_r.emergency = 1'b1; // [RULE8]
          next_r.state     = SEQ_RUN;
        end else if (sq.lvi_req || sq.clm_req) begin
          next_r.state     = SEQ_HOLD; // [RULE6] [RULE7]
          next_r.cnt       = CW'(HOLD_CYC - 1);
          next_r.sys_reset = 1'b1;
          next_r.emergency = 1'b0;
        end else if (r.cnt == '0) begin
          next_r.state = SEQ_RUN;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      SEQ_RUN: begin
        if (sq.wdt_req || sq.lvi_req || sq.clm_req) begin
          next_r.state     = SEQ_HOLD; // [RULE4] [RULE5] [RULE6] [RULE7]
          next_r.cnt       = CW'(HOLD_CYC - 1);
          next_r.sys_reset = 1'b1;
          next_r.emergency = 1'b0;
        end
      end
      default: begin
        next_r.state = SEQ_STAB;
        next_r.cnt   = CW'(STAB_CYC - 1);
      end
    endcase
    // Registered copy of the state decode, so the output comes from a flop.
    next_r.stab_wait = (next_r.state == SEQ_STAB);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.state     <= SEQ_STAB;
      r.cnt       <= CW'(STAB_CYC - 1);
      r.sys_reset <= 1'b0;
      r.emergency <= 1'b0;
      r.stab_wait <= 1'b1;
      r.hit       <= 3'h0;
    end else begin
      r <= next_r;
    end
  end

  assign sq.sys_reset = r.sys_reset;
  assign sq.stab_wait = r.stab_wait;
  assign sq.emergency = r.emergency;
  assign sq.hit       = r.hit;

endmodule
`default_nettype wire

//--- sim/rsf_top_props.sv
// Port-level checker for the reset source flag block.
`timescale 1ns/1ps
`default_nettype none
module rsf_top_props
  import rsf_pkg::*;
#(
  parameter int STAB_CYC = STAB_CYCLES,
  parameter int HOLD_CYC = HOLD_CYCLES
) (
  // Clock, pin reset and APB.
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  // Reset and wake sources.
  input wire logic              watchdog_reset_request,
  input wire logic              low_voltage_reset_request,
  input wire logic              oscillation_stop_request,
  input wire logic              nmi_request,
  input wire logic              maskable_request,
  input wire logic              interrupts_enabled_state,
  // Block outputs.
  input wire logic              system_reset,
  input wire logic              stabilization_wait,
  input wire logic              cpu_on_internal_clock,
  input wire logic              standby_active,
  input wire logic              wake_branch,
  input wire logic              wake_continue
);
  int hcnt;
  int scnt;

  // Lengths of the current hold and stabilisation phases.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt <= 0;
      scnt <= 0;
    end else begin
      hcnt <= system_reset ? hcnt + 1 : 0;
      scnt <= stabilization_wait ? scnt + 1 : 0;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  chk_access_ready: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready missing in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_unmapped_err: assert property (pready && paddr[11:5] != 0 |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  chk_flag_reserved: assert property (pready && !pwrite && paddr == OFF_FLAGS
      |-> (prdata & ~32'h0000_0013) == 0)
    else $error("reserved flag bits read non-zero");
  chk_wdt_reset: assert property (watchdog_reset_request && !stabilization_wait && !system_reset
      |=> system_reset)
    else $error("watchdog request did not reset");
  chk_src_reset: assert property ((low_voltage_reset_request || oscillation_stop_request)
      && !stabilization_wait && !system_reset |=> system_reset)
    else $error("detector request did not reset");
  chk_hold_len: assert property ($fell(system_reset) |-> hcnt == HOLD_CYC)
    else $error("internal reset hold length wrong");
  chk_hold_stab: assert property ($fell(system_reset) |-> stabilization_wait)
    else $error("no stabilisation wait after internal reset");
  chk_stab_len: assert property ($fell(stabilization_wait) && !cpu_on_internal_clock
      |-> scnt >= STAB_CYC && scnt <= STAB_CYC + 1)
    else $error("stabilisation wait length wrong");
  chk_emerg_entry: assert property (watchdog_reset_request && stabilization_wait && !system_reset
      |=> cpu_on_internal_clock && !system_reset)
    else $error("emergency mode not entered");
  chk_wake_nmi: assert property (standby_active && nmi_request && !system_reset
      |=> wake_branch && !wake_continue && !standby_active)
    else $error("nmi wake did not branch");
  chk_wake_masked: assert property (standby_active && !nmi_request && maskable_request
      && !interrupts_enabled_state |=> wake_continue && !wake_branch)
    else $error("disabled maskable wake did not continue");
endmodule
`default_nettype wire

//--- sim/rsf_src_model.sv
// Behavioural model of the reset sources and the CPU wake side.
`timescale 1ns/1ps
`default_nettype none
module rsf_src_model (
  // Clock.
  input  wire logic       pclk,
  // Commands: {watchdog, low voltage, clock stop} and {nmi, maskable, ei, outranks}.
  input  wire logic [2:0] fire,
  input  wire logic [3:0] wake,
  // Requests and CPU state towards the block.
  output logic      [2:0] req = 3'b000,
  output logic      [3:0] cpu = 4'h0
);
  // Only reset requests, wake requests and CPU state leave here; no register traffic runs in emergency mode.
  always_ff @(posedge pclk) begin
    req <= fire;
    cpu <= wake;
  end
endmodule
`default_nettype wire

//--- sim/reset_source_flags_test.sv
// Testbench for the reset source flag block.
`timescale 1ns/1ps
`default_nettype none
module reset_source_flags_test;
  import rsf_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, wake;
  logic [2:0]  fire;
  logic        system_reset, stabilization_wait, cpu_on_internal_clock;
  logic        standby_active, low_voltage_standby, wake_branch, wake_continue;
  wire         watchdog_reset_request, low_voltage_reset_request, oscillation_stop_request;
  wire         nmi_request, maskable_request, interrupts_enabled_state, request_outranks_current;
  int          mismatches, n_tests;

  rsf_top #(.STAB_CYC(8), .HOLD_CYC(3)) u_dut (.*);
  rsf_src_model u_src (
    .pclk (pclk),
    .fire (fire),
    .wake (wake),
    .req  ({watchdog_reset_request, low_voltage_reset_request, oscillation_stop_request}),
    .cpu  ({nmi_request, maskable_request, interrupts_enabled_state, request_outranks_current})
  );

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk(nm, rd, exp);
  endtask

  task automatic arm();
    apb(1'b1, OFF_PROTECT, {24'h00_0000, PROTECT_KEY}, 4'hF);
  endtask

  task automatic settle();
    int n;
    n = 0;
    while ((system_reset | stabilization_wait) !== 1'b0 && n < 100) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 100) mismatches++;
  endtask

  // Commands the source model for one cycle and stops where its effect shows.
  task automatic pulse(input logic [2:0] f, input logic [3:0] wk);
    @(posedge pclk);
    fire <= f;
    wake <= wk;
    @(posedge pclk);
    fire <= 3'b000;
    wake <= 4'h0;
    repeat (2) @(negedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [2:0]  SRC [3] = '{3'b100, 3'b010, 3'b001};
  localparam logic [31:0] ACC [3] = '{32'h0000_0010, 32'h0000_0011, 32'h0000_0013};
  localparam logic [3:0]  WK  [4] = '{4'h8, 4'h7, 4'h6, 4'h5};
  localparam logic [1:0]  WX  [4] = '{2'b10, 2'b10, 2'b01, 2'b01};

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, fire, wake} = '0;
    mismatches = 0;
    n_tests = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    settle();
    rdc("flags after pin reset", OFF_FLAGS, 32'h0000_0000);
    arm();
    rdc("key armed", OFF_PROTECT, 32'h0000_0001);
    apb(1'b1, OFF_FLAGS, 32'h0000_00FF, 4'hF);
    rdc("plain flag write", OFF_FLAGS, 32'h0000_0000);
    arm();
    apb(1'b1, OFF_FLAGS, 32'h0000_00FF, 4'hF);
    rdc("protected flag write", OFF_FLAGS, 32'h0000_0013);
    arm();
    apb(1'b1, OFF_FLAGS, 32'h0000_0000, 4'hF);
    for (int i = 0; i < 3; i++) begin
      pulse(SRC[i], 4'h0);
      chk("internal reset", system_reset, 1'b1);
      settle();
      rdc("flags after source", OFF_FLAGS, ACC[i]);
    end
    arm();
    apb(1'b1, OFF_BITOP, 32'h0000_0004, 4'h3);
    rdc("bit clear", OFF_FLAGS, 32'h0000_0003);
    apb(1'b1, OFF_BITOP, 32'h0000_0001, 4'h3);
    rdc("unarmed bit op", OFF_BITOP, 32'h0000_0003);
    apb(1'b0, 12'h020, 32'h0000_0000, 4'h0);
    chk("unmapped error", err, 1'b1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFF_CTRL, {30'h0, i[0], 1'b1}, 4'hF);
      @(negedge pclk);
      chk("low voltage standby", low_voltage_standby, i[0]);
      rdc("status in standby", OFF_STATUS, {30'h0, i[0], 1'b1});
      pulse(3'b000, WK[i]);
      chk("wake kind", {wake_branch, wake_continue}, WX[i]);
      chk("standby left", standby_active, 1'b0);
    end
    apb(1'b1, OFF_CTRL, 32'h0000_0001, 4'hF);
    pulse(3'b010, 4'h0);
    chk("reset wake pulse", {wake_branch, wake_continue}, 2'b00);
    settle();
    chk("standby after reset", standby_active, 1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    pulse(3'b100, 4'h0);
    settle();
    chk("emergency clock", cpu_on_internal_clock, 1'b1);
    pulse(3'b010, 4'h0);
    settle();
    chk("emergency left", cpu_on_internal_clock, 1'b0);
    rdc("flags after emergency", OFF_FLAGS, 32'h0000_0001);
    finish_test();
  end

  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    finish_test();
  end
endmodule

bind rsf_top rsf_top_props #(.STAB_CYC(STAB_CYC), .HOLD_CYC(HOLD_CYC)) u_props (.*);
`default_nettype wire
